// ===== verilog/ptd_map.vh
// Constants for the pre-trip input and diagnostic display block
`ifndef PTD_MAP_VH
`define PTD_MAP_VH

// Clock and base tick
`define PTD_CLK_HZ        40000000
`define PTD_TICK_US       1000
`define PTD_TICK_CYC      ((`PTD_CLK_HZ / 1000000) * `PTD_TICK_US)

// Times counted in 1 ms ticks; blink gap counted in blink slots
`define PTD_DEB_MS        10
`define PTD_INIT_MS       50
`define PTD_HOLD_MS       1000
`define PTD_SEC_MS        1000
`define PTD_BLINK_ON_MS   250
`define PTD_BLINK_SLOT_MS 500
`define PTD_BLINK_GAP     2

// Lamp cycling and diagnostic page count
`define PTD_CYCLE_S       20
`define PTD_NUM_CYCLES    24
`define PTD_NUM_PAGES     5

// Wishbone register byte offsets
`define PTD_REG_CTRL      8'h00
`define PTD_REG_STATUS    8'h04
`define PTD_REG_NAME_IDX  8'h08
`define PTD_REG_NAME_DAT  8'h0C
`define PTD_REG_MODE_TIME 8'h10

// CTRL fields
`define PTD_CTRL_NAME_OK  0
`define PTD_CTRL_PAT_LSB  8
`define PTD_CTRL_RESET    32'h0000FF00

// Wireless name layout
`define PTD_PREFIX_LEN    3
`define PTD_VIN_LEN       17
`define PTD_NAME_LEN      20

`endif

// ===== verilog/ptd_core.v
// Pre-trip trigger inputs, lamp-cycling mode control and diagnostic LED display
// Overview of operation
// - Four discrete inputs: two asserted low, two asserted high.
// - Low-asserted inputs are pulled up, so floating reads inactive.
// - Brief low pulse on first low input requests the lamp sequence.
// - Brief high pulse on first high input requests the lamp sequence.
// - Second low input is unused and affects nothing.
// - Second high input is ignition run; high means key in run.
// - First ignition run after install lights greens 1-4 after name update.
// - After an ignition cycle, greens 1-4 stay off during run.
// - Trigger starts sequence only in park, brake applied, engine running.
// - Lamp-cycling mode ends by itself after about eight minutes.
// - Releasing parking brake stops mode; after reapply a press restarts.
// - Ignition on wakes module and runs initialization before anything else.
// - Wireless name is fixed prefix followed by the vehicle ident number.
// - Fuse indicator lights when fuse open, load connected, relay on.
// - Five selectable diagnostic pages of status on the LEDs.
// - Amber indicator repeatedly blinks the selected page number.
// - Button selects pages only with ignition on; N presses give page N.
// - Each further press advances the page by one.
// - Press held one second or more counts as one valid press.
// - Four greens show the status bits of the selected page.
// - Page one: green n lit while relay n is active.
// - Pages 2-5: outputs, preconditions, mode and triggers, pairing.
// - Each lamp cycle lasts twenty seconds; mode ends after 24 cycles.
// - Start needs zero speed; second press or leaving park exits.
`include "ptd_map.vh"
`default_nettype none

module ptd_core #(
  parameter integer TICK_CYCLES = `PTD_TICK_CYC,
  parameter [23:0]  NAME_PREFIX = 24'h505452  // Arbitrary value
) (
  // Clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // Wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // Discrete wire inputs
  input  wire        trig_lo_n_i,
  input  wire        spare_lo_n_i,
  input  wire        trig_hi_i,
  input  wire        ign_run_i,
  // Vehicle and operator status
  input  wire        test_btn_i,
  input  wire        park_brake_i,
  input  wire        in_park_i,
  input  wire        speed_zero_i,
  input  wire        engine_run_i,
  input  wire        paired_i,
  input  wire [3:0]  fuse_open_i,
  input  wire [3:0]  load_conn_i,
  // Lamp drives and indicators
  output reg  [3:0]  relay_o,
  output reg  [3:0]  low_current_output_o,
  output reg  [3:0]  fuse_led_o,
  output reg  [3:0]  green_led_o,
  output reg         page_blink_indicator_o,
  output reg         mode_active_o
);

  localparam S_OFF  = 2'h0;
  localparam S_INIT = 2'h1;
  localparam S_RUN  = 2'h2;
  localparam M_IDLE = 1'b0;
  localparam M_ACT  = 1'b1;
  localparam [31:0] CTRL_RST = `PTD_CTRL_RESET;
  integer i;

  // Input bit positions after conditioning
  localparam B_TLO = 3'h0;
  localparam B_THI = 3'h1;
  localparam B_IGN = 3'h2;
  localparam B_BTN = 3'h3;
  localparam B_BRK = 3'h4;
  localparam B_PRK = 3'h5;
  localparam B_SPD = 3'h6;
  localparam B_ENG = 3'h7;

  function [9:0] inc10;
    input [9:0] v;
    begin
      inc10 = v + 10'h001;
    end
  endfunction

  // Millisecond tick divider
  reg [15:0] div_ff;
  reg        tick_ff;
  always @(posedge clk_i) begin
    if (rst_i) begin
      div_ff  <= 16'h0000;
      tick_ff <= 1'b0;
    end else if (div_ff == TICK_CYCLES[15:0] - 16'h0001) begin
      div_ff  <= 16'h0000;
      tick_ff <= 1'b1;
    end else begin
      div_ff  <= div_ff + 16'h0001;
      tick_ff <= 1'b0;
    end
  end

  // input polarity; pulled-up low inputs read idle when open, spare is ignored
  wire [7:0] raw_in = {engine_run_i, speed_zero_i, in_park_i, park_brake_i,
                       test_btn_i, ign_run_i, trig_hi_i, ~trig_lo_n_i};

  reg [7:0] sync1_ff;
  reg [7:0] sync2_ff;
  reg [7:0] clean_ff;
  reg [7:0] clean_d_ff;
  reg [3:0] deb_cnt_ff [0:7];

  always @(posedge clk_i) begin
    if (rst_i) begin
      sync1_ff   <= 8'h00;
      sync2_ff   <= 8'h00;
      clean_ff   <= 8'h00;
      clean_d_ff <= 8'h00;
      for (i = 0; i < 8; i = i + 1)
        deb_cnt_ff[i] <= 4'h0;
    end else begin
      sync1_ff   <= raw_in;
      sync2_ff   <= sync1_ff;
      clean_d_ff <= clean_ff;
      for (i = 0; i < 8; i = i + 1) begin
        if (sync2_ff[i] == clean_ff[i]) begin
          deb_cnt_ff[i] <= 4'h0;
        end else if (tick_ff) begin
          if (deb_cnt_ff[i] == `PTD_DEB_MS - 1) begin
            clean_ff[i]   <= sync2_ff[i];
            deb_cnt_ff[i] <= 4'h0;
          end else begin
            deb_cnt_ff[i] <= deb_cnt_ff[i] + 4'h1;
          end
        end
      end
    end
  end

  wire [7:0] rise = clean_ff & ~clean_d_ff;
  wire [7:0] fall = ~clean_ff & clean_d_ff;

  // wake on ignition run with an init period
  reg [1:0] pwr_ff;
  reg [9:0] init_ms_ff;
  reg       first_done_ff;
  always @(posedge clk_i) begin
    if (rst_i) begin
      pwr_ff        <= S_OFF;
      init_ms_ff    <= 10'h000;
      first_done_ff <= 1'b0;
    end else begin
      case (pwr_ff)
        S_OFF: begin
          init_ms_ff <= 10'h000;
          if (clean_ff[B_IGN])
            pwr_ff <= S_INIT;
        end
        S_INIT: begin
          if (!clean_ff[B_IGN])
            pwr_ff <= S_OFF;
          else if (tick_ff) begin
            if (init_ms_ff == `PTD_INIT_MS - 1)
              pwr_ff <= S_RUN;
            else
              init_ms_ff <= inc10(init_ms_ff);
          end
        end
        S_RUN: begin
          if (!clean_ff[B_IGN]) begin
            pwr_ff <= S_OFF;
            // later ignition cycles are no longer first run
            first_done_ff <= 1'b1;
          end
        end
        default: pwr_ff <= S_OFF;
      endcase
    end
  end
  wire running = (pwr_ff == S_RUN);

  // Registers written by software
  reg       name_ok_ff;
  reg [7:0] pattern_ff;
  reg [4:0] name_idx_ff;
  reg [7:0] vin_mem [0:`PTD_VIN_LEN-1];

  // either trigger wire, only one is installed
  wire trig_press = running & (rise[B_TLO] | rise[B_THI]);

  wire can_start = clean_ff[B_PRK] & clean_ff[B_BRK] & clean_ff[B_ENG] & clean_ff[B_SPD];

  // Lamp-cycling mode
  reg        mode_ff;
  reg [9:0]  ms_ff;
  reg [4:0]  sec_ff;
  reg [4:0]  cyc_ff;
  wire sec_wrap = tick_ff & (ms_ff == `PTD_SEC_MS - 1);
  wire cyc_end  = sec_wrap & (sec_ff == `PTD_CYCLE_S - 1);
  always @(posedge clk_i) begin
    if (rst_i) begin
      mode_ff <= M_IDLE;
      ms_ff   <= 10'h000;
      sec_ff  <= 5'h00;
      cyc_ff  <= 5'h00;
    end else begin
      case (mode_ff)
        M_IDLE: begin
          ms_ff  <= 10'h000;
          sec_ff <= 5'h00;
          cyc_ff <= 5'h00;
          // start only with all conditions met
          if (trig_press && can_start)
            mode_ff <= M_ACT;
        end
        M_ACT: begin
          if (tick_ff)
            ms_ff <= sec_wrap ? 10'h000 : inc10(ms_ff);
          if (sec_wrap)
            sec_ff <= cyc_end ? 5'h00 : sec_ff + 5'h01;
          if (cyc_end)
            cyc_ff <= cyc_ff + 5'h01;
          // brake release stops at once; press or leaving park exits
          if (!running || !clean_ff[B_BRK] || !clean_ff[B_PRK] || trig_press)
            mode_ff <= M_IDLE;
          // self stop after 24 cycles of 20 s
          else if (cyc_end && cyc_ff == `PTD_NUM_CYCLES - 1)
            mode_ff <= M_IDLE;
        end
        default: mode_ff <= M_IDLE;
      endcase
    end
  end

  reg [10:0] hold_ff;
  reg        press_ok_ff;
  always @(posedge clk_i) begin
    if (rst_i) begin
      hold_ff     <= 11'h000;
      press_ok_ff <= 1'b0;
    end else begin
      press_ok_ff <= 1'b0;
      if (clean_ff[B_BTN]) begin
        if (tick_ff && hold_ff != `PTD_HOLD_MS)
          hold_ff <= hold_ff + 11'h001;
      end else begin
        hold_ff <= 11'h000;
        if (fall[B_BTN] && hold_ff == `PTD_HOLD_MS)
          press_ok_ff <= 1'b1;
      end
    end
  end

  // Page select, 0 is normal operation
  reg [2:0] page_ff;
  always @(posedge clk_i) begin
    if (rst_i) begin
      page_ff <= 3'h0;
    end else if (!running) begin
      page_ff <= 3'h0;
    end else if (press_ok_ff) begin
      // advance one per press, wrap from five
      if (page_ff == `PTD_NUM_PAGES)
        page_ff <= 3'h1;
      else
        page_ff <= page_ff + 3'h1;
    end
  end

  // amber blinks page count, then a gap of idle slots
  reg [9:0] bl_ms_ff;
  reg [2:0] bl_slot_ff;
  always @(posedge clk_i) begin
    if (rst_i || page_ff == 3'h0 || press_ok_ff) begin
      bl_ms_ff   <= 10'h000;
      bl_slot_ff <= 3'h0;
    end else if (tick_ff) begin
      if (bl_ms_ff == `PTD_BLINK_SLOT_MS - 1) begin
        bl_ms_ff <= 10'h000;
        if (bl_slot_ff == page_ff + `PTD_BLINK_GAP - 1)
          bl_slot_ff <= 3'h0;
        else
          bl_slot_ff <= bl_slot_ff + 3'h1;
      end else begin
        bl_ms_ff <= inc10(bl_ms_ff);
      end
    end
  end

  // Page contents
  reg [3:0] nxt_green;
  wire [3:0] relay_on = {4{mode_ff}} & pattern_ff[3:0];
  wire [3:0] lco_on   = {4{mode_ff}} & pattern_ff[7:4];
  always @* begin
    case (page_ff)
      3'h0: nxt_green = (!first_done_ff && name_ok_ff) ? 4'hF : 4'h0;
      3'h1: nxt_green = relay_on;
      3'h2: nxt_green = lco_on;
      3'h3: nxt_green = {1'b0, clean_ff[B_PRK], clean_ff[B_SPD], clean_ff[B_BRK]};
      3'h4: nxt_green = {1'b0, clean_ff[B_TLO], clean_ff[B_THI], mode_ff};
      3'h5: nxt_green = {3'b000, paired_i};
      default: nxt_green = 4'h0;
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      relay_o                <= 4'h0;
      low_current_output_o   <= 4'h0;
      fuse_led_o             <= 4'h0;
      green_led_o            <= 4'h0;
      page_blink_indicator_o <= 1'b0;
      mode_active_o          <= 1'b0;
    end else begin
      relay_o              <= relay_on;
      low_current_output_o <= lco_on;
      // blown fuse on an energised, loaded output
      fuse_led_o           <= fuse_open_i & load_conn_i & relay_on;
      green_led_o          <= running ? nxt_green : 4'h0;
      page_blink_indicator_o <= (page_ff != 3'h0) && ({2'b00, bl_slot_ff} < {2'b00, page_ff})
                                && (bl_ms_ff < `PTD_BLINK_ON_MS);
      mode_active_o        <= mode_ff;
    end
  end

  // advertised name: prefix then stored ident number
  reg [7:0] name_char;
  always @* begin
    if (name_idx_ff < `PTD_PREFIX_LEN)
      name_char = NAME_PREFIX[23 - 8 * name_idx_ff -: 8];
    else if (name_idx_ff < `PTD_NAME_LEN)
      name_char = vin_mem[name_idx_ff - `PTD_PREFIX_LEN];
    else
      name_char = 8'h00;
  end

  // Wishbone classic slave, one wait state, unmapped reads give zero
  wire wb_req = wb_cyc_i & wb_stb_i;
  wire wb_wr  = wb_req & wb_we_i & wb_ack_o;
  reg [31:0] nxt_rdata;
  always @* begin
    case (wb_adr_i)
      `PTD_REG_CTRL:      nxt_rdata = {16'h0000, pattern_ff, 7'h00, name_ok_ff};
      `PTD_REG_STATUS:    nxt_rdata = {16'h0000, clean_ff, 1'b0, page_ff,
                                       first_done_ff, running, pwr_ff != S_OFF, mode_ff};
      `PTD_REG_NAME_IDX:  nxt_rdata = {27'h0000000, name_idx_ff};
      `PTD_REG_NAME_DAT:  nxt_rdata = {24'h000000, name_char};
      `PTD_REG_MODE_TIME: nxt_rdata = {22'h000000, cyc_ff, sec_ff};
      default:            nxt_rdata = 32'h00000000;
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o    <= 1'b0;
      wb_dat_o    <= 32'h00000000;
      name_ok_ff  <= CTRL_RST[`PTD_CTRL_NAME_OK];
      pattern_ff  <= CTRL_RST[`PTD_CTRL_PAT_LSB +: 8];
      name_idx_ff <= 5'h00;
    end else begin
      wb_ack_o <= wb_req & ~wb_ack_o;
      if (wb_req && !wb_ack_o)
        wb_dat_o <= nxt_rdata;
      if (wb_wr && wb_adr_i == `PTD_REG_CTRL) begin
        if (wb_sel_i[0])
          name_ok_ff <= wb_dat_i[`PTD_CTRL_NAME_OK];
        if (wb_sel_i[1])
          pattern_ff <= wb_dat_i[15:8];
      end
      if (wb_wr && wb_adr_i == `PTD_REG_NAME_IDX && wb_sel_i[0])
        name_idx_ff <= wb_dat_i[4:0];
    end
  end

  // Ident storage has no reset; contents are loaded by software
  always @(posedge clk_i) begin
    if (wb_wr && wb_adr_i == `PTD_REG_NAME_DAT && wb_sel_i[0]
        && name_idx_ff >= `PTD_PREFIX_LEN && name_idx_ff < `PTD_NAME_LEN)
      vin_mem[name_idx_ff - `PTD_PREFIX_LEN] <= wb_dat_i[7:0];
  end

endmodule

`default_nettype wire

// ===== tb/ptd_chk.sv
// Concurrent checks on the pre-trip block ports
`default_nettype none
module ptd_chk #(
  parameter integer TICK_CYCLES = 4
) (
  // Clock, reset and bus handshake
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_ack_o,
  // Vehicle status
  input wire logic       ign_run_i,
  input wire logic       park_brake_i,
  input wire logic       in_park_i,
  input wire logic       speed_zero_i,
  input wire logic       engine_run_i,
  input wire logic [3:0] fuse_open_i,
  input wire logic [3:0] load_conn_i,
  // Drives and indicators
  input wire logic [3:0] relay_o,
  input wire logic [3:0] fuse_led_o,
  input wire logic [3:0] green_led_o,
  input wire logic       page_blink_indicator_o,
  input wire logic       mode_active_o
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int EXIT_MAX = 1000;
  // Ignition debounce plus a margin for tick alignment
  localparam int OFF_CYC = 16 * TICK_CYCLES;
  logic [19:0] off_cnt_ff;
  wire  [3:0]  fuse_cond = fuse_open_i & load_conn_i;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  always_ff @(posedge clk_i) begin
    if (rst_i || ign_run_i)
      off_cnt_ff <= 20'h00000;
    else if (off_cnt_ff != 20'(OFF_CYC))
      off_cnt_ff <= off_cnt_ff + 20'h00001;
  end
  sequence brake_drop_s;
    mode_active_o && $fell(park_brake_i) ##1 !park_brake_i [*8];
  endsequence
  sequence park_drop_s;
    mode_active_o && $fell(in_park_i) ##1 !in_park_i [*8];
  endsequence
  ack_next_a:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered next cycle");
  ack_pulse_a:
    assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_cause_a:
    assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  relay_mode_a:
    assert property (relay_o != 4'h0 |-> ##[0:1] mode_active_o)
    else $error("relay driven outside lamp mode");
  fuse_cause_a:
    assert property ((fuse_led_o & ~(($past(fuse_cond) | $past(fuse_cond, 3))
      & (relay_o | $past(relay_o)))) == 4'h0)
    else $error("fuse indicator without its cause");
  start_gate_a:
    assert property ($rose(mode_active_o) |->
      park_brake_i && in_park_i && speed_zero_i && engine_run_i)
    else $error("lamp mode started without preconditions");
  brake_exit_a:
    assert property (brake_drop_s |-> ##[1:EXIT_MAX] !mode_active_o)
    else $error("lamp mode kept after brake release");
  park_exit_a:
    assert property (park_drop_s |-> ##[1:EXIT_MAX] !mode_active_o)
    else $error("lamp mode kept after leaving park");
  ign_off_a:
    assert property (off_cnt_ff == 20'(OFF_CYC) |->
      green_led_o == 4'h0 && !mode_active_o && !page_blink_indicator_o)
    else $error("indication while ignition off");
endmodule
bind ptd_core ptd_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .ign_run_i, .park_brake_i,
  .in_park_i, .speed_zero_i, .engine_run_i, .fuse_open_i, .load_conn_i,
  .relay_o, .fuse_led_o, .green_led_o, .page_blink_indicator_o, .mode_active_o
);
`default_nettype wire

// ===== tb/ptd_veh.sv
// Vehicle switches, ignition and operator model
`default_nettype none
module ptd_veh #(
  parameter int TICK = 4
) (
  // Clock
  input  wire logic       clk_i,
  // Lines seen by the block
  output var  logic       trig_lo_n_o,
  output var  logic       spare_lo_n_o,
  output var  logic       trig_hi_o,
  output var  logic       ign_o,
  output var  logic       btn_o,
  output var  logic       brake_o,
  output var  logic       park_o,
  output var  logic       spd0_o,
  output var  logic       eng_o,
  output var  logic       paired_o,
  output var  logic [3:0] fuse_o,
  output var  logic [3:0] load_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic spare_wig = 1'b0;
  initial begin
    trig_lo_n_o = 1'b1;
    {trig_hi_o, ign_o, btn_o, paired_o} = 4'h0;
    {brake_o, park_o, spd0_o, eng_o} = 4'hF;
    {fuse_o, load_o} = 8'h00;
  end
  // Unused line may pick up noise in a real harness
  always @(posedge clk_i)
    spare_lo_n_o <= spare_wig ? ~spare_lo_n_o : 1'b1;
  task automatic drive(input int sel, input logic on);
    case (sel)
      0: trig_lo_n_o <= ~on;
      1: trig_hi_o <= on;
      default: btn_o <= on;
    endcase
  endtask
  // one switch at a time, contact bounce, then held for ms
  task automatic press(input int sel, input int ms);
    for (int i = 0; i < 6; i++) begin
      @(posedge clk_i);
      drive(sel, i[0]);
    end
    repeat (ms * TICK) @(posedge clk_i);
    drive(sel, 1'b0);
    repeat (20 * TICK) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// ===== tb/testbench.sv
// Self-checking bench for the pre-trip block
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int TICK = 4;
  // Full sequence needs about 50k cycles
  localparam int LIMIT = 90000;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wb_cyc = 1'b0;
  logic        wb_stb = 1'b0;
  logic        wb_we = 1'b0;
  logic [7:0]  wb_adr = 8'h00;
  logic [31:0] wb_wdat = 32'h00000000;
  logic [31:0] rdat;
  wire  [31:0] wb_dat_o;
  wire         wb_ack_o, tlo_n, spare_n, thi, ign, btn, brk, prk, spd0, eng, pair;
  wire  [3:0]  fuse, load, relay, low_current_output, fled, green;
  wire         amber, mode;
  int          error_cnt = 0;
  int          num_checks = 0;
  int          cyc_cnt = 0;
  always #12.5 clk_i = ~clk_i;
  ptd_veh #(.TICK(TICK)) veh (
    .clk_i(clk_i), .trig_lo_n_o(tlo_n), .spare_lo_n_o(spare_n), .trig_hi_o(thi),
    .ign_o(ign), .btn_o(btn), .brake_o(brk), .park_o(prk), .spd0_o(spd0),
    .eng_o(eng), .paired_o(pair), .fuse_o(fuse), .load_o(load)
  );
  ptd_core #(.TICK_CYCLES(TICK)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_wdat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .trig_lo_n_i(tlo_n),
    .spare_lo_n_i(spare_n), .trig_hi_i(thi), .ign_run_i(ign), .test_btn_i(btn),
    .park_brake_i(brk), .in_park_i(prk), .speed_zero_i(spd0), .engine_run_i(eng),
    .paired_i(pair), .fuse_open_i(fuse), .load_conn_i(load), .relay_o(relay),
    .low_current_output_o(low_current_output), .fuse_led_o(fled), .green_led_o(green),
    .page_blink_indicator_o(amber), .mode_active_o(mode)
  );
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == LIMIT) begin
      error_cnt++;
      finish_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic ms(input int n);
    repeat (n * TICK) @(posedge clk_i);
  endtask
  // Classic cycle; only the global cycle limit ends a lost answer
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_wdat} <= {2'b11, we, a, d};
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1) @(posedge clk_i);
    rdat = wb_dat_o;
    {wb_cyc, wb_stb} <= 2'b00;
  endtask
  task automatic t_regs();
    wb(1'b0, 8'h00, 32'h0);
    chk(rdat, 32'h0000FF00);
    wb(1'b1, 8'h08, 32'h00000013);
    wb(1'b0, 8'h08, 32'h0);
    chk(rdat, 32'h00000013);
    wb(1'b1, 8'h40, 32'hFFFFFFFF);
    wb(1'b0, 8'h40, 32'h0);
    chk(rdat, 32'h00000000);
  endtask
  task automatic t_wake();
    veh.ign_o <= 1'b1;
    ms(5);
    veh.press(0, 15);
    ms(40);
    wb(1'b0, 8'h04, 32'h0);
    chk({rdat[2], mode}, 2'b10);
    wb(1'b1, 8'h00, 32'h0000FF01);
    ms(1);
    chk(green, 4'hF);
    veh.ign_o <= 1'b0;
    ms(30);
    veh.ign_o <= 1'b1;
    ms(70);
    chk(green, 4'h0);
    wb(1'b0, 8'h04, 32'h0);
    chk(rdat[3:2], 2'b11);
  endtask
  task automatic t_trig();
    veh.spare_wig <= 1'b1;
    veh.brake_o <= 1'b0;
    ms(20);
    veh.press(0, 15);
    chk(mode, 1'b0);
    {veh.brake_o, veh.spd0_o} <= 2'b10;
    ms(20);
    veh.press(0, 15);
    chk(mode, 1'b0);
    veh.spd0_o <= 1'b1;
    ms(20);
    veh.press(0, 15);
    chk({mode, low_current_output, relay}, 9'h1FF);
    wb(1'b1, 8'h00, 32'h00005A01);
    {veh.fuse_o, veh.load_o} <= 8'hB3;
    ms(1);
    chk({low_current_output, relay, fled}, 12'h5A2);
    veh.press(0, 15);
    chk(mode, 1'b0);
    veh.spare_wig <= 1'b0;
    veh.press(1, 15);
    chk(mode, 1'b1);
    veh.brake_o <= 1'b0;
    ms(20);
    chk(mode, 1'b0);
    veh.brake_o <= 1'b1;
    ms(20);
    veh.press(1, 15);
    chk(mode, 1'b1);
    veh.park_o <= 1'b0;
    ms(20);
    chk(mode, 1'b0);
    veh.park_o <= 1'b1;
    ms(20);
    veh.press(1, 15);
    ms(2000);
    wb(1'b0, 8'h10, 32'h0);
    chk(rdat, 32'h00000002);
  endtask
  task automatic t_pages();
    int   n;
    logic p;
    n = 0;
    veh.paired_o <= 1'b1;
    veh.press(2, 1100);
    chk(green, 4'hA);
    veh.press(2, 500);
    chk(green, 4'hA);
    veh.press(2, 1100);
    chk(green, 4'h5);
    veh.press(2, 1100);
    chk(green, 4'h7);
    repeat (2500 * TICK) begin
      p = amber;
      @(posedge clk_i);
      if (amber === 1'b1 && p === 1'b0) n++;
    end
    chk(n, 3);
    veh.press(2, 1100);
    chk(green, 4'h1);
    veh.press(2, 1100);
    chk(green, 4'h1);
    veh.press(2, 1100);
    chk(green, 4'hA);
    veh.ign_o <= 1'b0;
    ms(30);
    chk({mode, green}, 5'h00);
  endtask
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_wake();
    t_trig();
    t_pages();
    finish_test();
  end
endmodule
`default_nettype wire
